//--- core/rod_pkg.sv
package rod_pkg;

	// ****************************************
	// Widths and field positions
	// ****************************************
	localparam int BYTE_W   = 8;
	localparam int WORD_W   = 16;
	localparam int LONG_W   = 32;
	localparam int FLD_W    = 5;
	localparam int MODE_BIT = 15;
	localparam int OPC_HI   = 14;
	localparam int OPC_LO   = 10;
	localparam int DST_HI   = 9;
	localparam int DST_LO   = 5;
	localparam int SRC_HI   = 4;
	localparam int SRC_LO   = 0;

	// ****************************************
	// Operation codes
	// ****************************************
	localparam logic [4:0] OPC_COPY    = 5'h00;
	localparam logic [4:0] OPC_LOAD    = 5'h01;
	localparam logic [4:0] OPC_STORE   = 5'h02;
	localparam logic [4:0] OPC_CALL    = 5'h03;
	localparam logic [4:0] OPC_CFLAGS  = 5'h04;
	localparam logic [4:0] OPC_INREG   = 5'h05;
	localparam logic [4:0] OPC_OUTREG  = 5'h06;
	localparam logic [4:0] OPC_SPARE_A = 5'h07;
	localparam logic [4:0] OPC_ADD     = 5'h08;
	localparam logic [4:0] OPC_ADD_WITH_CARRY    = 5'h09;
	localparam logic [4:0] OPC_ADDBYTE = 5'h0a;
	localparam logic [4:0] OPC_ADDUNS  = 5'h0b;
	localparam logic [4:0] OPC_SUB     = 5'h0c;
	localparam logic [4:0] OPC_SUBBOR  = 5'h0d;
	localparam logic [4:0] OPC_SUBBYTE = 5'h0e;
	localparam logic [4:0] OPC_COMP    = 5'h0f;
	localparam logic [4:0] OPC_AND     = 5'h10;
	localparam logic [4:0] OPC_OR      = 5'h11;
	localparam logic [4:0] OPC_XOR     = 5'h12;
	localparam logic [4:0] OPC_NOT     = 5'h13;
	localparam logic [4:0] OPC_BITRST  = 5'h14;
	localparam logic [4:0] OPC_BITSET  = 5'h15;
	localparam logic [4:0] OPC_BITTST  = 5'h16;
	localparam logic [4:0] OPC_SPARE_B = 5'h17;
	localparam logic [4:0] OPC_LSH     = 5'h18;
	localparam logic [4:0] OPC_ASH     = 5'h19;
	localparam logic [4:0] OPC_CSH     = 5'h1a;
	localparam logic [4:0] OPC_SMUL    = 5'h1b;
	localparam logic [4:0] OPC_BCOPY   = 5'h1c;
	localparam logic [4:0] OPC_BSWAP   = 5'h1d;
	localparam logic [4:0] OPC_SDIV    = 5'h1e;
	localparam logic [4:0] OPC_COND    = 5'h1f;

	// ****************************************
	// Source register codes and write masks
	// ****************************************
	localparam logic [4:0] SRC_RSV_A    = 5'h17;
	localparam logic [4:0] SRC_RSV_B    = 5'h1f;
	localparam logic [4:0] SRC_LONG_LIT = 5'h1f;
	localparam logic [4:0] SRC_PAIR_A   = 5'h15;
	localparam logic [4:0] SRC_PAIR_B   = 5'h1d;
	localparam logic [3:0] MASK_NONE    = 4'h0;
	localparam logic [3:0] MASK_BYTE    = 4'h1;
	localparam logic [3:0] MASK_WORD    = 4'h3;
	localparam logic [3:0] MASK_LONG    = 4'hf;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {AM_DIRECT, AM_REG_IND, AM_STACK_IND, AM_ABSOLUTE} rod_amode_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_LIT} rod_size_t;
	typedef enum logic {ST_IDLE, ST_EXT} rod_state_t;
	typedef enum logic [5:0] {
		OP_PLAIN_COPY, OP_LOAD_DATA, OP_LOAD_PROG, OP_POP, OP_WRITE_DATA,
		OP_WRITE_PROG, OP_PUSH, OP_CALL, OP_COPY_FLAGS, OP_INPUT_REG,
		OP_OUTPUT_REG, OP_ADD, OP_ADD_CARRY, OP_ADD_BYTE, OP_ADD_UNS, OP_SUB,
		OP_SUB_BORROW, OP_SUB_BYTE, OP_COMPARE, OP_AND, OP_OR, OP_XOR, OP_NOT,
		OP_BIT_RESET, OP_BIT_SET, OP_BIT_TEST, OP_LSHIFT, OP_ASHIFT, OP_CSHIFT,
		OP_SMUL, OP_BYTE_COPY, OP_BYTE_SWAP, OP_SDIV, OP_JUMP, OP_GOTO,
		OP_ILLEGAL
	} rod_op_t;

endpackage : rod_pkg

//--- core/rod_size_conv.sv
`timescale 1ns/1ps
module rod_size_conv (
	input  wire logic [31:0]     srcData,
	input  rod_pkg::rod_size_t   srcSize,
	input  wire logic            dstLong,
	input  wire logic            byteOp,
	output logic [31:0]          result,
	output logic [3:0]           wrMask
);

	// ****************************************
	// Source widening and narrowing
	// ****************************************
	logic [31:0] litExt;
	logic [31:0] wordExt;

	assign litExt  = {{(rod_pkg::LONG_W-rod_pkg::FLD_W){srcData[rod_pkg::FLD_W-1]}},
		srcData[rod_pkg::FLD_W-1:0]};
	assign wordExt = {{(rod_pkg::LONG_W-rod_pkg::WORD_W){srcData[rod_pkg::WORD_W-1]}},
		srcData[rod_pkg::WORD_W-1:0]};

	always_comb begin
		result = '0;
		wrMask = rod_pkg::MASK_NONE;
		if (byteOp) begin
			result[rod_pkg::BYTE_W-1:0] = srcData[rod_pkg::BYTE_W-1:0];
			wrMask = rod_pkg::MASK_BYTE;
		end else if (!dstLong) begin
			wrMask = rod_pkg::MASK_WORD;
			case (srcSize)
				rod_pkg::SZ_LIT: result[rod_pkg::WORD_W-1:0] = litExt[rod_pkg::WORD_W-1:0];
				rod_pkg::SZ_LONG: result[rod_pkg::WORD_W-1:0] = srcData[rod_pkg::WORD_W-1:0];
				default: result[rod_pkg::WORD_W-1:0] = srcData[rod_pkg::WORD_W-1:0];
			endcase
		end else begin
			wrMask = rod_pkg::MASK_LONG;
			case (srcSize)
				rod_pkg::SZ_LIT: result = litExt;
				rod_pkg::SZ_LONG: result = srcData;
				default: result = wordExt;
			endcase
		end
	end

endmodule : rod_size_conv

//--- core/rod_decode.sv
// What this block does
// - Mode bit one makes the source field a literal, zero a register selector.
// - Register-indirect source comes from memory addressed by the named register.
// - Source codes 0-15 are single registers; others extras or pairs; two reserved.
// - Register-indirect allowed only on data load, data store and input register.
// - Stack-indirect addresses memory by stack pointer; pop and push only.
// - Absolute takes address from second word; load, store, input, output only.
// - Source and destination sizes may differ; the block converts.
// - Word destination writes 16 bits; literal sign-extended, word passed.
// - Word destination from long source keeps only low 16 bits.
// - Long destination writes 32 bits; literal and word sign-extended.
// - Long destination from long source writes the value unchanged.
// - Byte instructions store only eight bits into any destination.
// - Operation comes from instruction bits 14 down to 10.
// - Code 00001 is data load, program load or pop, by mode.
// - Code 00010 is data store, program store or push, by mode.
// - Codes 00000 to 00110 are copy, call, flag copy, input, output.
// - Codes 01000 to 01111 are the add, subtract and compare group.
// - Codes 10000 to 10110 are logic and bit operations.
// - Codes 11000 to 11110 are shifts, multiply, byte ops, divide.
// - Code 11111 is jump with register source, branch with literal.
// - Codes 00111 and 10111 are spare and decode as illegal.
`timescale 1ns/1ps
module rod_decode (
	input  wire logic               ref_clk,
	input  wire logic               arst_n,
	input  wire logic               instrValid,
	input  wire logic [15:0]        instrWord,
	input  rod_pkg::rod_amode_t     instrMode,
	output logic                    instrReady,
	output logic                    decValid_q,
	output rod_pkg::rod_op_t        opKind_q,
	output logic                    illegal_q,
	output logic                    srcLit_q,
	output logic [4:0]              srcReg_q,
	output logic                    srcPair_q,
	output logic [4:0]              dstReg_q,
	output rod_pkg::rod_amode_t     amode_q,
	output logic                    memSrc_q,
	output logic [31:0]             litValue_q,
	output logic [15:0]             extWord_q,
	input  wire logic               mvValid,
	input  wire logic [31:0]        mvData,
	input  rod_pkg::rod_size_t      mvSrcSize,
	input  wire logic               mvDstLong,
	input  wire logic               mvByte,
	output logic                    mvDone_q,
	output logic [31:0]             mvResult_q,
	output logic [3:0]              mvMask_q
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rstMeta_q;
	logic rstSync_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	assign instrReady = rstSync_q;

	// ****************************************
	// Operation decode
	// ****************************************
	function automatic rod_pkg::rod_op_t opFromCode(
		input logic [4:0]          opc,
		input logic                lit,
		input rod_pkg::rod_amode_t md
	);
		rod_pkg::rod_op_t op;
		op = rod_pkg::OP_ILLEGAL;
		case (opc)
			rod_pkg::OPC_COPY:    op = rod_pkg::OP_PLAIN_COPY;
			rod_pkg::OPC_LOAD: begin
				if (md == rod_pkg::AM_STACK_IND)
					op = rod_pkg::OP_POP;
				else if (md == rod_pkg::AM_DIRECT && lit)
					op = rod_pkg::OP_LOAD_PROG;
				else if (md != rod_pkg::AM_DIRECT)
					op = rod_pkg::OP_LOAD_DATA;
			end
			rod_pkg::OPC_STORE: begin
				if (md == rod_pkg::AM_STACK_IND)
					op = rod_pkg::OP_PUSH;
				else if (md == rod_pkg::AM_DIRECT && lit)
					op = rod_pkg::OP_WRITE_PROG;
				else if (md != rod_pkg::AM_DIRECT)
					op = rod_pkg::OP_WRITE_DATA;
			end
			rod_pkg::OPC_CALL:    op = rod_pkg::OP_CALL;
			rod_pkg::OPC_CFLAGS:  op = rod_pkg::OP_COPY_FLAGS;
			rod_pkg::OPC_INREG:   op = rod_pkg::OP_INPUT_REG;
			rod_pkg::OPC_OUTREG:  op = rod_pkg::OP_OUTPUT_REG;
			rod_pkg::OPC_ADD:     op = rod_pkg::OP_ADD;
			rod_pkg::OPC_ADD_WITH_CARRY:    op = rod_pkg::OP_ADD_CARRY;
			rod_pkg::OPC_ADDBYTE: op = rod_pkg::OP_ADD_BYTE;
			rod_pkg::OPC_ADDUNS:  op = rod_pkg::OP_ADD_UNS;
			rod_pkg::OPC_SUB:     op = rod_pkg::OP_SUB;
			rod_pkg::OPC_SUBBOR:  op = rod_pkg::OP_SUB_BORROW;
			rod_pkg::OPC_SUBBYTE: op = rod_pkg::OP_SUB_BYTE;
			rod_pkg::OPC_COMP:    op = rod_pkg::OP_COMPARE;
			rod_pkg::OPC_AND:     op = rod_pkg::OP_AND;
			rod_pkg::OPC_OR:      op = rod_pkg::OP_OR;
			rod_pkg::OPC_XOR:     op = rod_pkg::OP_XOR;
			rod_pkg::OPC_NOT:     op = rod_pkg::OP_NOT;
			rod_pkg::OPC_BITRST:  op = rod_pkg::OP_BIT_RESET;
			rod_pkg::OPC_BITSET:  op = rod_pkg::OP_BIT_SET;
			rod_pkg::OPC_BITTST:  op = rod_pkg::OP_BIT_TEST;
			rod_pkg::OPC_LSH:     op = rod_pkg::OP_LSHIFT;
			rod_pkg::OPC_ASH:     op = rod_pkg::OP_ASHIFT;
			rod_pkg::OPC_CSH:     op = rod_pkg::OP_CSHIFT;
			rod_pkg::OPC_SMUL:    op = rod_pkg::OP_SMUL;
			rod_pkg::OPC_BCOPY:   op = rod_pkg::OP_BYTE_COPY;
			rod_pkg::OPC_BSWAP:   op = rod_pkg::OP_BYTE_SWAP;
			rod_pkg::OPC_SDIV:    op = rod_pkg::OP_SDIV;
			rod_pkg::OPC_COND:    op = lit ? rod_pkg::OP_GOTO : rod_pkg::OP_JUMP;
			default:              op = rod_pkg::OP_ILLEGAL;
		endcase
		return op;
	endfunction : opFromCode

	// Mode legality per operation
	function automatic logic modeOk(
		input rod_pkg::rod_op_t    op,
		input logic                lit,
		input logic [4:0]          src,
		input rod_pkg::rod_amode_t md
	);
		logic ok;
		ok = 1'b1;
		case (md)
			rod_pkg::AM_REG_IND:
				ok = !lit && src != rod_pkg::SRC_RSV_A && src != rod_pkg::SRC_RSV_B
					&& (op == rod_pkg::OP_LOAD_DATA || op == rod_pkg::OP_WRITE_DATA
					|| op == rod_pkg::OP_INPUT_REG);
			rod_pkg::AM_STACK_IND:
				ok = !lit && (op == rod_pkg::OP_POP || op == rod_pkg::OP_PUSH);
			rod_pkg::AM_ABSOLUTE:
				ok = !lit && (op == rod_pkg::OP_LOAD_DATA || op == rod_pkg::OP_WRITE_DATA
					|| op == rod_pkg::OP_INPUT_REG || op == rod_pkg::OP_OUTPUT_REG);
			default:
				ok = lit || src != rod_pkg::SRC_RSV_A;
		endcase
		return ok && op != rod_pkg::OP_ILLEGAL;
	endfunction : modeOk

	// ****************************************
	// Instruction word sequencing
	// ****************************************
	rod_pkg::rod_state_t  state_q, state_d;
	logic [15:0]          held_q, held_d;
	rod_pkg::rod_amode_t  heldMode_q, heldMode_d;
	logic [15:0]          decWord;
	rod_pkg::rod_amode_t  decMode;
	logic [4:0]           decOpc;
	logic [4:0]           decSrc;
	logic                 decLit;
	logic                 needExt;
	logic                 issue;
	rod_pkg::rod_op_t     decOp;
	logic                 decOk;

	assign decWord = (state_q == rod_pkg::ST_EXT) ? held_q : instrWord;
	assign decMode = (state_q == rod_pkg::ST_EXT) ? heldMode_q : instrMode;
	assign decOpc  = decWord[rod_pkg::OPC_HI:rod_pkg::OPC_LO];
	assign decSrc  = decWord[rod_pkg::SRC_HI:rod_pkg::SRC_LO];
	assign decLit  = decWord[rod_pkg::MODE_BIT];
	assign needExt = (instrMode == rod_pkg::AM_ABSOLUTE)
		|| (instrMode == rod_pkg::AM_DIRECT && !instrWord[rod_pkg::MODE_BIT]
		&& instrWord[rod_pkg::SRC_HI:rod_pkg::SRC_LO] == rod_pkg::SRC_LONG_LIT);
	assign issue   = instrValid && instrReady
		&& (state_q == rod_pkg::ST_EXT || !needExt);
	assign decOp   = opFromCode(decOpc, decLit, decMode);
	assign decOk   = modeOk(decOp, decLit, decSrc, decMode);

	always_comb begin
		state_d    = state_q;
		held_d     = held_q;
		heldMode_d = heldMode_q;
		case (state_q)
			rod_pkg::ST_IDLE: begin
				if (instrValid && instrReady && needExt) begin
					state_d    = rod_pkg::ST_EXT;
					held_d     = instrWord;
					heldMode_d = instrMode;
				end
			end
			rod_pkg::ST_EXT: begin
				if (instrValid)
					state_d = rod_pkg::ST_IDLE;
			end
			default: state_d = rod_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			state_q    <= rod_pkg::ST_IDLE;
			held_q     <= '0;
			heldMode_q <= rod_pkg::AM_DIRECT;
		end else begin
			state_q    <= state_d;
			held_q     <= held_d;
			heldMode_q <= heldMode_d;
		end
	end

	// ****************************************
	// Decoded outputs
	// ****************************************
	logic                decValid_d;
	rod_pkg::rod_op_t    opKind_d;
	logic                illegal_d;
	logic                srcLit_d;
	logic [4:0]          srcReg_d;
	logic                srcPair_d;
	logic [4:0]          dstReg_d;
	rod_pkg::rod_amode_t amode_d;
	logic                memSrc_d;
	logic [31:0]         litValue_d;
	logic [15:0]         extWord_d;

	always_comb begin
		decValid_d = issue;
		opKind_d   = opKind_q;
		illegal_d  = illegal_q;
		srcLit_d   = srcLit_q;
		srcReg_d   = srcReg_q;
		srcPair_d  = srcPair_q;
		dstReg_d   = dstReg_q;
		amode_d    = amode_q;
		memSrc_d   = memSrc_q;
		litValue_d = litValue_q;
		extWord_d  = extWord_q;
		if (issue) begin
			opKind_d   = decOk ? decOp : rod_pkg::OP_ILLEGAL;
			illegal_d  = !decOk;
			srcLit_d   = decLit;
			srcReg_d   = decLit ? '0 : decSrc;
			srcPair_d  = !decLit && decSrc[rod_pkg::FLD_W-1]
				&& (!decSrc[0] || decSrc == rod_pkg::SRC_PAIR_A
				|| decSrc == rod_pkg::SRC_PAIR_B);
			dstReg_d   = decWord[rod_pkg::DST_HI:rod_pkg::DST_LO];
			amode_d    = decMode;
			memSrc_d   = decOk && decMode != rod_pkg::AM_DIRECT;
			litValue_d = decLit ? {{(rod_pkg::LONG_W-rod_pkg::FLD_W){decSrc[rod_pkg::FLD_W-1]}},
				decSrc} : '0;
			extWord_d  = (state_q == rod_pkg::ST_EXT) ? instrWord : '0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			decValid_q <= 1'b0;
			opKind_q   <= rod_pkg::OP_ILLEGAL;
			illegal_q  <= 1'b0;
			srcLit_q   <= 1'b0;
			srcReg_q   <= '0;
			srcPair_q  <= 1'b0;
			dstReg_q   <= '0;
			amode_q    <= rod_pkg::AM_DIRECT;
			memSrc_q   <= 1'b0;
			litValue_q <= '0;
			extWord_q  <= '0;
		end else begin
			decValid_q <= decValid_d;
			opKind_q   <= opKind_d;
			illegal_q  <= illegal_d;
			srcLit_q   <= srcLit_d;
			srcReg_q   <= srcReg_d;
			srcPair_q  <= srcPair_d;
			dstReg_q   <= dstReg_d;
			amode_q    <= amode_d;
			memSrc_q   <= memSrc_d;
			litValue_q <= litValue_d;
			extWord_q  <= extWord_d;
		end
	end

	// ****************************************
	// Data movement size conversion
	// ****************************************
	logic [31:0] convResult;
	logic [3:0]  convMask;
	logic        mvDone_d;
	logic [31:0] mvResult_d;
	logic [3:0]  mvMask_d;

	rod_size_conv rod_size_conv_i (
		.srcData (mvData),
		.srcSize (mvSrcSize),
		.dstLong (mvDstLong),
		.byteOp  (mvByte),
		.result  (convResult),
		.wrMask  (convMask)
	);

	always_comb begin
		mvDone_d   = mvValid;
		mvResult_d = mvValid ? convResult : mvResult_q;
		mvMask_d   = mvValid ? convMask : mvMask_q;
	end

	always_ff @(posedge ref_clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			mvDone_q   <= 1'b0;
			mvResult_q <= '0;
			mvMask_q   <= rod_pkg::MASK_NONE;
		end else begin
			mvDone_q   <= mvDone_d;
			mvResult_q <= mvResult_d;
			mvMask_q   <= mvMask_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstSync_q);

	sequence s_absFirst;
		instrValid && instrReady && state_q == rod_pkg::ST_IDLE
			&& instrMode == rod_pkg::AM_ABSOLUTE;
	endsequence

	sequence s_extTaken;
		state_q == rod_pkg::ST_EXT && instrValid;
	endsequence

	a_literal_flag: assert property (issue |=> decValid_q
		&& srcLit_q == $past(decLit) && (srcLit_q || srcReg_q == $past(decSrc)))
		else $error("literal flag or source register wrong");

	a_regind_mem: assert property (issue && decOk && decMode == rod_pkg::AM_REG_IND
		|=> memSrc_q && srcReg_q == $past(decSrc))
		else $error("register-indirect source not from memory");

	a_reserved_src: assert property (issue && decMode == rod_pkg::AM_REG_IND
		&& (decSrc == rod_pkg::SRC_RSV_A || decSrc == rod_pkg::SRC_RSV_B)
		|=> illegal_q && opKind_q == rod_pkg::OP_ILLEGAL)
		else $error("reserved source code accepted");

	a_regind_ops: assert property (decValid_q && !illegal_q
		&& amode_q == rod_pkg::AM_REG_IND |-> opKind_q inside
		{rod_pkg::OP_LOAD_DATA, rod_pkg::OP_WRITE_DATA, rod_pkg::OP_INPUT_REG})
		else $error("register-indirect on wrong operation");

	a_stack_ops: assert property (decValid_q && !illegal_q
		&& amode_q == rod_pkg::AM_STACK_IND |-> memSrc_q
		&& opKind_q inside {rod_pkg::OP_POP, rod_pkg::OP_PUSH})
		else $error("stack-indirect on wrong operation");

	a_abs_second: assert property (s_absFirst ##1 s_extTaken
		|=> decValid_q && extWord_q == $past(instrWord))
		else $error("absolute address word not taken");

	a_word_literal: assert property (mvValid && !mvByte && !mvDstLong
		&& mvSrcSize == rod_pkg::SZ_LIT |=> mvMask_q == rod_pkg::MASK_WORD
		&& $signed(mvResult_q[15:0]) == $signed($past(mvData[4:0]))
		&& mvResult_q[31:16] == 16'h0000)
		else $error("word literal not sign-extended");

	a_word_trunc: assert property (mvValid && !mvByte && !mvDstLong
		&& mvSrcSize == rod_pkg::SZ_LONG |=> mvResult_q[15:0] == $past(mvData[15:0])
		&& mvResult_q[31:16] == 16'h0000)
		else $error("long source not truncated");

	a_long_word: assert property (mvValid && !mvByte && mvDstLong
		&& mvSrcSize == rod_pkg::SZ_WORD |=> mvMask_q == rod_pkg::MASK_LONG
		&& $signed(mvResult_q) == $signed($past(mvData[15:0])))
		else $error("word source not sign-extended to long");

	a_byte_only: assert property (mvValid && mvByte |=> mvDone_q
		&& mvMask_q == rod_pkg::MASK_BYTE && mvResult_q[31:8] == 24'h000000)
		else $error("byte store wider than eight bits");

	a_spare_code: assert property (issue && (decOpc == rod_pkg::OPC_SPARE_A
		|| decOpc == rod_pkg::OPC_SPARE_B) |=> illegal_q)
		else $error("spare operation code decoded");

	a_cond_goto: assert property (issue && decOpc == rod_pkg::OPC_COND && decLit
		&& decMode == rod_pkg::AM_DIRECT |=> opKind_q == rod_pkg::OP_GOTO)
		else $error("literal conditional not decoded as branch");

endmodule : rod_decode

//--- verif/rod_decode_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("MISMATCH %s exp %0h got %0h", nm, e, g); \
	end \
end
module rod_decode_tb;
	logic                ref_clk = 1'b0;
	logic                arst_n;
	logic                instrValid;
	logic [15:0]         instrWord;
	rod_pkg::rod_amode_t instrMode;
	logic                instrReady;
	logic                decValid_q;
	rod_pkg::rod_op_t    opKind_q;
	logic                illegal_q;
	logic                srcLit_q;
	logic [4:0]          srcReg_q;
	logic                srcPair_q;
	logic [4:0]          dstReg_q;
	rod_pkg::rod_amode_t amode_q;
	logic                memSrc_q;
	logic [31:0]         litValue_q;
	logic [15:0]         extWord_q;
	logic                mvValid;
	logic [31:0]         mvData;
	rod_pkg::rod_size_t  mvSrcSize;
	logic                mvDstLong;
	logic                mvByte;
	logic                mvDone_q;
	logic [31:0]         mvResult_q;
	logic [3:0]          mvMask_q;
	int                  failures = 0;
	int                  check_count = 0;

	always #50 ref_clk = ~ref_clk;

	rod_decode rod_decode_i (.ref_clk(ref_clk), .arst_n(arst_n), .instrValid(instrValid),
		.instrWord(instrWord), .instrMode(instrMode), .instrReady(instrReady),
		.decValid_q(decValid_q), .opKind_q(opKind_q), .illegal_q(illegal_q),
		.srcLit_q(srcLit_q), .srcReg_q(srcReg_q), .srcPair_q(srcPair_q), .dstReg_q(dstReg_q),
		.amode_q(amode_q), .memSrc_q(memSrc_q), .litValue_q(litValue_q),
		.extWord_q(extWord_q), .mvValid(mvValid), .mvData(mvData), .mvSrcSize(mvSrcSize),
		.mvDstLong(mvDstLong), .mvByte(mvByte), .mvDone_q(mvDone_q),
		.mvResult_q(mvResult_q), .mvMask_q(mvMask_q));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic conclude;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	function automatic rod_pkg::rod_op_t expOp(input int i);
		if (i >= 8 && i <= 15) return rod_pkg::rod_op_t'(int'(rod_pkg::OP_ADD) + i - 8);
		if (i >= 16 && i <= 22) return rod_pkg::rod_op_t'(int'(rod_pkg::OP_AND) + i - 16);
		if (i >= 24 && i <= 30) return rod_pkg::rod_op_t'(int'(rod_pkg::OP_LSHIFT) + i - 24);
		case (i)
			0: return rod_pkg::OP_PLAIN_COPY;
			3: return rod_pkg::OP_CALL;
			4: return rod_pkg::OP_COPY_FLAGS;
			5: return rod_pkg::OP_INPUT_REG;
			6: return rod_pkg::OP_OUTPUT_REG;
			31: return rod_pkg::OP_JUMP;
			default: return rod_pkg::OP_ILLEGAL;
		endcase
	endfunction : expOp

	// Offers one instruction, leaves valid high for back-to-back use
	task automatic dk(input logic [15:0] w, input rod_pkg::rod_amode_t md,
		input rod_pkg::rod_op_t op);
		logic two;
		logic ok;
		two = md == rod_pkg::AM_ABSOLUTE || (md == rod_pkg::AM_DIRECT && !w[15] && w[4:0] == 5'h1f);
		ok = op != rod_pkg::OP_ILLEGAL;
		instrValid = 1'b1;
		instrWord = w;
		instrMode = md;
		@(negedge ref_clk);
		if (two) begin
			`CHK("early", 1'b0, decValid_q)
			instrWord = 16'hbeef;
			@(negedge ref_clk);
		end
		`CHK("decValid", 1'b1, decValid_q)
		`CHK("opKind", op, opKind_q)
		`CHK("illegal", 1'(!ok), illegal_q)
		`CHK("memSrc", 1'(ok && md != rod_pkg::AM_DIRECT), memSrc_q)
		`CHK("dstReg", w[9:5], dstReg_q)
		if (ok) begin
			`CHK("extWord", two ? 16'hbeef : 16'h0000, extWord_q)
			`CHK("amode", md, amode_q)
		end
	endtask : dk

	task automatic idle;
		instrValid = 1'b0;
		@(negedge ref_clk);
		`CHK("decPulse", 1'b0, decValid_q)
	endtask : idle

	task automatic mv(input logic [31:0] d, input rod_pkg::rod_size_t sz, input logic dl,
		input logic by, input logic [31:0] er, input logic [3:0] em);
		mvValid = 1'b1;
		mvData = d;
		mvSrcSize = sz;
		mvDstLong = dl;
		mvByte = by;
		@(negedge ref_clk);
		`CHK("mvDone", 1'b1, mvDone_q)
		`CHK("mvResult", er, mvResult_q)
		`CHK("mvMask", em, mvMask_q)
	endtask : mv

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		int n;
		`CHK("rstOp", rod_pkg::OP_ILLEGAL, opKind_q)
		`CHK("rstMode", rod_pkg::AM_DIRECT, amode_q)
		`CHK("rstMask", 4'h0, mvMask_q)
		`CHK("rstReady", 1'b0, instrReady)
		arst_n = 1'b1;
		@(negedge ref_clk);
		`CHK("ready1", 1'b0, instrReady)
		n = 0;
		while (instrReady !== 1'b1 && n < 10) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 10) begin
			failures++;
			conclude();
		end
		`CHK("readyEdges", 1, n)
	endtask : t_reset

	task automatic t_opcodes;
		for (int i = 0; i < 32; i++) begin
			dk({1'b0, 5'(i), 5'h03, 5'h02}, rod_pkg::AM_DIRECT, expOp(i));
			`CHK("srcReg", 5'h02, srcReg_q)
			`CHK("srcLit", 1'b0, srcLit_q)
		end
		idle();
	endtask : t_opcodes

	task automatic t_modes;
		dk({6'h21, 5'h04, 5'h01}, rod_pkg::AM_DIRECT, rod_pkg::OP_LOAD_PROG);
		dk({6'h01, 5'h04, 5'h06}, rod_pkg::AM_STACK_IND, rod_pkg::OP_POP);
		dk({6'h01, 5'h04, 5'h0f}, rod_pkg::AM_REG_IND, rod_pkg::OP_LOAD_DATA);
		`CHK("srcRegInd", 5'h0f, srcReg_q)
		dk({6'h01, 5'h04, 5'h00}, rod_pkg::AM_ABSOLUTE, rod_pkg::OP_LOAD_DATA);
		dk({6'h22, 5'h07, 5'h01}, rod_pkg::AM_DIRECT, rod_pkg::OP_WRITE_PROG);
		dk({6'h02, 5'h07, 5'h06}, rod_pkg::AM_STACK_IND, rod_pkg::OP_PUSH);
		dk({6'h02, 5'h07, 5'h10}, rod_pkg::AM_REG_IND, rod_pkg::OP_WRITE_DATA);
		dk({6'h02, 5'h07, 5'h00}, rod_pkg::AM_ABSOLUTE, rod_pkg::OP_WRITE_DATA);
		dk({6'h05, 5'h04, 5'h1e}, rod_pkg::AM_REG_IND, rod_pkg::OP_INPUT_REG);
		dk({6'h06, 5'h04, 5'h03}, rod_pkg::AM_REG_IND, rod_pkg::OP_ILLEGAL);
		dk({6'h08, 5'h04, 5'h03}, rod_pkg::AM_REG_IND, rod_pkg::OP_ILLEGAL);
		dk({6'h01, 5'h04, 5'h17}, rod_pkg::AM_REG_IND, rod_pkg::OP_ILLEGAL);
		dk({6'h01, 5'h04, 5'h1f}, rod_pkg::AM_REG_IND, rod_pkg::OP_ILLEGAL);
		dk({6'h08, 5'h04, 5'h03}, rod_pkg::AM_STACK_IND, rod_pkg::OP_ILLEGAL);
		dk({6'h05, 5'h04, 5'h03}, rod_pkg::AM_STACK_IND, rod_pkg::OP_ILLEGAL);
		dk({6'h21, 5'h04, 5'h03}, rod_pkg::AM_STACK_IND, rod_pkg::OP_ILLEGAL);
		dk({6'h06, 5'h04, 5'h00}, rod_pkg::AM_ABSOLUTE, rod_pkg::OP_OUTPUT_REG);
		dk({6'h05, 5'h04, 5'h00}, rod_pkg::AM_ABSOLUTE, rod_pkg::OP_INPUT_REG);
		dk({6'h08, 5'h04, 5'h00}, rod_pkg::AM_ABSOLUTE, rod_pkg::OP_ILLEGAL);
		dk({6'h08, 5'h04, 5'h17}, rod_pkg::AM_DIRECT, rod_pkg::OP_ILLEGAL);
		idle();
	endtask : t_modes

	task automatic t_literal;
		dk({6'h28, 5'h09, 5'h10}, rod_pkg::AM_DIRECT, rod_pkg::OP_ADD);
		`CHK("litNeg", 32'hfffffff0, litValue_q)
		`CHK("litFlag", 1'b1, srcLit_q)
		`CHK("litReg", 5'h00, srcReg_q)
		dk({6'h28, 5'h09, 5'h0f}, rod_pkg::AM_DIRECT, rod_pkg::OP_ADD);
		`CHK("litPos", 32'h0000000f, litValue_q)
		dk({6'h28, 5'h09, 5'h17}, rod_pkg::AM_DIRECT, rod_pkg::OP_ADD);
		dk({6'h3f, 5'h09, 5'h05}, rod_pkg::AM_DIRECT, rod_pkg::OP_GOTO);
		dk({6'h1f, 5'h09, 5'h1f}, rod_pkg::AM_DIRECT, rod_pkg::OP_JUMP);
		dk({6'h08, 5'h09, 5'h10}, rod_pkg::AM_DIRECT, rod_pkg::OP_ADD);
		`CHK("pairEven", 1'b1, srcPair_q)
		dk({6'h08, 5'h09, 5'h11}, rod_pkg::AM_DIRECT, rod_pkg::OP_ADD);
		`CHK("pairOdd", 1'b0, srcPair_q)
		idle();
	endtask : t_literal

	task automatic t_move;
		mv(32'hffffffe5, rod_pkg::SZ_LIT, 1'b0, 1'b0, 32'h00000005, 4'h3);
		mv(32'h00000013, rod_pkg::SZ_LIT, 1'b0, 1'b0, 32'h0000fff3, 4'h3);
		mv(32'h00008001, rod_pkg::SZ_WORD, 1'b0, 1'b0, 32'h00008001, 4'h3);
		mv(32'h12345678, rod_pkg::SZ_LONG, 1'b0, 1'b0, 32'h00005678, 4'h3);
		mv(32'h00000013, rod_pkg::SZ_LIT, 1'b1, 1'b0, 32'hfffffff3, 4'hf);
		mv(32'h00008001, rod_pkg::SZ_WORD, 1'b1, 1'b0, 32'hffff8001, 4'hf);
		mv(32'h87654321, rod_pkg::SZ_LONG, 1'b1, 1'b0, 32'h87654321, 4'hf);
		mv(32'h1234abcd, rod_pkg::SZ_LONG, 1'b1, 1'b1, 32'h000000cd, 4'h1);
		mv(32'h1234abcd, rod_pkg::SZ_WORD, 1'b0, 1'b1, 32'h000000cd, 4'h1);
		mv(32'h0000f0a5, rod_pkg::SZ_BYTE, 1'b0, 1'b1, 32'h000000a5, 4'h1);
		mvValid = 1'b0;
		@(negedge ref_clk);
		`CHK("mvPulse", 1'b0, mvDone_q)
	endtask : t_move

	initial begin
		arst_n = 1'b0;
		instrValid = 1'b0;
		instrWord = 16'h0000;
		instrMode = rod_pkg::AM_DIRECT;
		mvValid = 1'b0;
		mvData = 32'h00000000;
		mvSrcSize = rod_pkg::SZ_WORD;
		mvDstLong = 1'b0;
		mvByte = 1'b0;
		repeat (3) @(negedge ref_clk);
		t_reset();
		t_opcodes();
		t_modes();
		t_literal();
		t_move();
		conclude();
	end
endmodule : rod_decode_tb
